// [core/dpg_pkg.sv]
// constants for the dual pulse generator with trigger start and capture
// assumes a 32-bit AXI4-Lite register slave and one system clock
package dpg_pkg;

   localparam int CW     = 10;
   localparam int ADDR_W = 6;
   localparam int NDATA  = 5;

   // register byte offsets
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 6'h00;
   localparam logic [ADDR_W-1:0] ADDR_CAPR = 6'h18;
   localparam logic [ADDR_W-1:0] ADDR_CAPF = 6'h1C;
   localparam logic [ADDR_W-1:0] ADDR_STAT = 6'h20;
   // dead_time_one, width_one, period_value, dead_time_two, width_two
   localparam logic [ADDR_W-1:0] DATA_OFS [NDATA] = '{6'h04, 6'h08, 6'h0C, 6'h10, 6'h14};
   localparam int IDX_DT1 = 0;
   localparam int IDX_W1  = 1;
   localparam int IDX_PER = 2;
   localparam int IDX_DT2 = 3;
   localparam int IDX_W2  = 4;

   // control and status register fields
   localparam int CTRL_RUN      = 0;
   localparam int CTRL_STOP_LSB = 1;
   localparam int CTRL_SRC_LSB  = 3;
   localparam int CTRL_EDGE     = 5;
   localparam int CTRL_INI1     = 6;
   localparam int CTRL_INI2     = 7;
   localparam int CTRL_MODE_LSB = 8;
   localparam int STAT_COUNT    = 0;
   localparam int STAT_WAIT     = 1;
   localparam int STAT_PROT     = 2;
   localparam int STAT_CNT_LSB  = 16;

   localparam logic [CW-1:0] CTRL_RST = 10'h000;
   localparam logic [CW-1:0] DATA_RST = 10'h000;
   localparam logic [CW:0]   FULL_PER = 11'h400;

   localparam logic [1:0] MODE_INDEP = 2'h0;
   localparam logic [1:0] MODE_VAR   = 2'h2;
   localparam logic [1:0] MODE_HALF  = 2'h3;
   localparam logic [1:0] STOP_INIT  = 2'h0;
   localparam logic [1:0] STOP_HOLD  = 2'h1;
   localparam logic [1:0] STOP_END   = 2'h2;
   localparam logic [1:0] SRC_CAP    = 2'h0;
   localparam logic [1:0] SRC_BOTH   = 2'h1;
   localparam logic [1:0] SRC_TRIG   = 2'h2;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h1,
      ST_WAIT  = 3'h2,
      ST_COUNT = 3'h4
   } dpg_state_t;

endpackage

// [core/dpg_top.sv]
// dual pulse generator: 10-bit counter, trigger start/stop, edge capture
// assumes AXI4-Lite master, trigger pin synchronous to clock_in
//
// The register offsets and the AXI4-Lite register port were decided locally.
module dpg_top #(
   parameter int ADDR_W = dpg_pkg::ADDR_W
) (
   // clock and reset
   input  wire logic              clock_in,
   input  wire logic              rstn_in,
   // axi4-lite write channels
   input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
   input  wire logic              s_axi_awvalid_in,
   output logic                   s_axi_awready_out,
   input  wire logic [31:0]       s_axi_wdata_in,
   input  wire logic [3:0]        s_axi_wstrb_in,
   input  wire logic              s_axi_wvalid_in,
   output logic                   s_axi_wready_out,
   output logic [1:0]             s_axi_bresp_out,
   output logic                   s_axi_bvalid_out,
   input  wire logic              s_axi_bready_in,
   // axi4-lite read channels
   input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
   input  wire logic              s_axi_arvalid_in,
   output logic                   s_axi_arready_out,
   output logic [31:0]            s_axi_rdata_out,
   output logic [1:0]             s_axi_rresp_out,
   output logic                   s_axi_rvalid_out,
   input  wire logic              s_axi_rready_in,
   // trigger pin
   input  wire logic              ext_trigger_in,
   // pulse outputs and events
   output logic                   pulse_out_one_out,
   output logic                   pulse_out_two_out,
   output logic                   period_match_irq_out,
   output logic                   trigger_start_irq_out
);

   localparam int CW = dpg_pkg::CW;

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave
   logic                aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
   logic [ADDR_W-1:0]   aw_addr_r;
   logic [31:0]         wdata_r;
   logic [3:0]          wstrb_r;
   logic                do_wr, wr_hit, rd_take, rd_hit, rvalid_nxt;
   logic [31:0]         rd_val;

   assign do_wr       = aw_full_r && w_full_r && !s_axi_bvalid_out;
   assign aw_full_nxt = (s_axi_awvalid_in && s_axi_awready_out) ? 1'b1 :
                        (do_wr ? 1'b0 : aw_full_r);
   assign w_full_nxt  = (s_axi_wvalid_in && s_axi_wready_out) ? 1'b1 :
                        (do_wr ? 1'b0 : w_full_r);
   assign rd_take     = s_axi_arvalid_in && s_axi_arready_out;
   assign rvalid_nxt  = rd_take ? 1'b1 : (s_axi_rready_in ? 1'b0 : s_axi_rvalid_out);

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         aw_full_r         <= 1'b0;
         s_axi_awready_out <= 1'b0;
         aw_addr_r         <= '0;
      end else begin
         aw_full_r         <= aw_full_nxt;
         s_axi_awready_out <= !aw_full_nxt;
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_addr_r <= s_axi_awaddr_in;
         end
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         w_full_r         <= 1'b0;
         s_axi_wready_out <= 1'b0;
         wdata_r          <= 32'h0000_0000;
         wstrb_r          <= 4'h0;
      end else begin
         w_full_r         <= w_full_nxt;
         s_axi_wready_out <= !w_full_nxt;
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            wdata_r <= s_axi_wdata_in;
            wstrb_r <= s_axi_wstrb_in;
         end
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out  <= dpg_pkg::RESP_OKAY;
      end else if (do_wr) begin
         s_axi_bvalid_out <= 1'b1;
         s_axi_bresp_out  <= wr_hit ? dpg_pkg::RESP_OKAY : dpg_pkg::RESP_SLVERR;
      end else if (s_axi_bready_in) begin
         s_axi_bvalid_out <= 1'b0;
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s_axi_rvalid_out  <= 1'b0;
         s_axi_arready_out <= 1'b0;
         s_axi_rdata_out   <= 32'h0000_0000;
         s_axi_rresp_out   <= dpg_pkg::RESP_OKAY;
      end else begin
         s_axi_rvalid_out  <= rvalid_nxt;
         s_axi_arready_out <= !rvalid_nxt;
         if (rd_take) begin
            s_axi_rdata_out <= rd_hit ? rd_val : 32'h0000_0000;
            s_axi_rresp_out <= rd_hit ? dpg_pkg::RESP_OKAY : dpg_pkg::RESP_SLVERR;
         end
      end
   end

   // byte-lane merge into a 10-bit register
   function automatic logic [CW-1:0] merge10(input logic [CW-1:0] old,
                                             input logic [31:0]   d,
                                             input logic [3:0]    s);
      logic [CW-1:0] m;
      m = old;
      if (s[0]) m[7:0] = d[7:0];
      if (s[1]) m[CW-1:8] = d[CW-1:8];
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [CW-1:0]       ctrl_r;
   logic [CW-1:0]       dreg_r [dpg_pkg::NDATA];
   logic [dpg_pkg::NDATA-1:0] data_wr;
   logic                ctrl_wr, per_hi_wr;
   logic [CW-1:0]       ctrl_new;
   logic [1:0]          src_new, stop_new;

   assign ctrl_wr   = do_wr && (aw_addr_r == dpg_pkg::ADDR_CTRL);
   assign per_hi_wr = data_wr[dpg_pkg::IDX_PER] && wstrb_r[1];
   // source and stop fields written together with the run bit take effect at once
   assign ctrl_new  = merge10(ctrl_r, wdata_r, wstrb_r);
   assign src_new   = ctrl_new[dpg_pkg::CTRL_SRC_LSB +: 2];
   assign stop_new  = ctrl_new[dpg_pkg::CTRL_STOP_LSB +: 2];

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctrl_r <= dpg_pkg::CTRL_RST;
      end else if (ctrl_wr) begin
         ctrl_r <= ctrl_new;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < dpg_pkg::NDATA; gi++) begin : g_data
         assign data_wr[gi] = do_wr && (aw_addr_r == dpg_pkg::DATA_OFS[gi]);
         always_ff @(posedge clock_in or negedge rstn_in) begin
            if (!rstn_in) begin
               dreg_r[gi] <= dpg_pkg::DATA_RST;
            end else if (data_wr[gi]) begin
               dreg_r[gi] <= merge10(dreg_r[gi], wdata_r, wstrb_r);
            end
         end
      end
   endgenerate

   always_comb begin
      wr_hit = ctrl_wr || (|data_wr) || (aw_addr_r == dpg_pkg::ADDR_STAT) ||
               (aw_addr_r == dpg_pkg::ADDR_CAPR) || (aw_addr_r == dpg_pkg::ADDR_CAPF);
   end

   logic       run_r, edge_sel, ini1, ini2;
   logic [1:0] stop_sel, src_sel, mode_sel;
   logic       trig_mode;

   assign run_r     = ctrl_r[dpg_pkg::CTRL_RUN];
   assign stop_sel  = ctrl_r[dpg_pkg::CTRL_STOP_LSB +: 2];
   assign src_sel   = ctrl_r[dpg_pkg::CTRL_SRC_LSB +: 2];
   assign edge_sel  = ctrl_r[dpg_pkg::CTRL_EDGE];
   assign ini1      = ctrl_r[dpg_pkg::CTRL_INI1];
   assign ini2      = ctrl_r[dpg_pkg::CTRL_INI2];
   assign mode_sel  = ctrl_r[dpg_pkg::CTRL_MODE_LSB +: 2];
   assign trig_mode = (src_sel == dpg_pkg::SRC_BOTH) || (src_sel == dpg_pkg::SRC_TRIG);

   ////////////////////////////////////////////////////////////////////////////
   // trigger pin
   logic pin_d_r, rise, fall, start_edge, stop_lvl;

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pin_d_r <= 1'b0;
      end else begin
         pin_d_r <= ext_trigger_in;
      end
   end

   assign rise       = ext_trigger_in && !pin_d_r;
   assign fall       = !ext_trigger_in && pin_d_r;
   assign start_edge = edge_sel ? rise : fall;
   assign stop_lvl   = ext_trigger_in ^ edge_sel;

   ////////////////////////////////////////////////////////////////////////////
   // counter and sequencing
   dpg_pkg::dpg_state_t st_r, st_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic [CW:0]   per_c_r;
   logic          stop_pend_r, stop_pend_nxt;
   logic          pend, load_init, per_evt, trg_evt, cnt_zero;
   logic          cmd_start, cmd_stop, start_ok, stop_ok, one_time;

   assign cmd_start = ctrl_wr && wstrb_r[0] && wdata_r[dpg_pkg::CTRL_RUN];
   assign cmd_stop  = ctrl_wr && wstrb_r[0] && !wdata_r[dpg_pkg::CTRL_RUN] && run_r;
   assign start_ok  = run_r && trig_mode && !stop_pend_r;
   assign stop_ok   = (run_r || stop_pend_r) && trig_mode;
   assign one_time  = (stop_sel == dpg_pkg::STOP_END) || stop_pend_r;
   assign pend      = (st_r == dpg_pkg::ST_COUNT) && ({1'b0, cnt_r} == per_c_r - 11'h001);

   always_comb begin
      st_nxt        = st_r;
      cnt_nxt       = cnt_r;
      stop_pend_nxt = stop_pend_r;
      load_init     = 1'b0;
      per_evt       = 1'b0;
      trg_evt       = 1'b0;
      cnt_zero      = 1'b0;
      case (st_r)
         dpg_pkg::ST_IDLE: begin
         end
         dpg_pkg::ST_WAIT: begin
            if (start_ok && start_edge) begin
               st_nxt    = dpg_pkg::ST_COUNT;
               cnt_nxt   = '0;
               cnt_zero  = 1'b1;
               load_init = 1'b1;
               trg_evt   = 1'b1;
            end
         end
         dpg_pkg::ST_COUNT: begin
            if (pend) begin
               per_evt  = 1'b1;
               cnt_nxt  = '0;
               cnt_zero = 1'b1;
               if (one_time) begin
                  load_init     = 1'b1;
                  stop_pend_nxt = 1'b0;
                  st_nxt = (trig_mode && !stop_pend_r) ? dpg_pkg::ST_WAIT : dpg_pkg::ST_IDLE;
               end
            end else begin
               cnt_nxt = cnt_r + 10'h001;
            end
         end
         default: st_nxt = dpg_pkg::ST_IDLE;
      endcase
      if (stop_ok && stop_lvl && (st_r != dpg_pkg::ST_IDLE)) begin
         st_nxt        = stop_pend_r ? dpg_pkg::ST_IDLE : dpg_pkg::ST_WAIT;
         stop_pend_nxt = 1'b0;
         cnt_nxt       = '0;
         cnt_zero      = 1'b1;
         load_init     = 1'b1;
         trg_evt       = 1'b0;
         per_evt       = 1'b0;
      end
      if (cmd_stop) begin
         case (stop_new)
            dpg_pkg::STOP_INIT: begin
               st_nxt    = dpg_pkg::ST_IDLE;
               cnt_nxt   = '0;
               load_init = 1'b1;
            end
            dpg_pkg::STOP_HOLD: begin
               st_nxt    = dpg_pkg::ST_IDLE;
               cnt_nxt   = '0;
               load_init = 1'b0;
            end
            default: begin
               if (st_r == dpg_pkg::ST_COUNT && !pend) begin
                  stop_pend_nxt = 1'b1;
               end else begin
                  st_nxt    = dpg_pkg::ST_IDLE;
                  load_init = 1'b1;
               end
            end
         endcase
      end
      if (cmd_start) begin
         stop_pend_nxt = 1'b0;
         cnt_nxt       = '0;
         cnt_zero      = 1'b1;
         per_evt       = 1'b0;
         trg_evt       = 1'b0;
         if (src_new == dpg_pkg::SRC_TRIG) begin
            st_nxt    = dpg_pkg::ST_WAIT;
            load_init = 1'b0;
         end else if (src_new == dpg_pkg::SRC_BOTH && stop_lvl) begin
            st_nxt    = dpg_pkg::ST_WAIT;
            load_init = 1'b1;
         end else begin
            st_nxt    = dpg_pkg::ST_COUNT;
            load_init = 1'b1;
         end
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_r        <= dpg_pkg::ST_IDLE;
         cnt_r       <= '0;
         stop_pend_r <= 1'b0;
      end else begin
         st_r        <= st_nxt;
         cnt_r       <= cnt_nxt;
         stop_pend_r <= stop_pend_nxt;
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         period_match_irq_out  <= 1'b0;
         trigger_start_irq_out <= 1'b0;
      end else begin
         period_match_irq_out  <= per_evt;
         trigger_start_irq_out <= trg_evt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // compare stage, loaded at period match, start or trigger stop after a write to the period high byte
   logic          xfer_pend_r;
   logic [CW:0]   per_x, w1_x, w2_x, half_x;
   logic [CW:0]   on_nxt [2];
   logic [CW:0]   off_nxt [2];
   logic [CW:0]   on_r [2];
   logic [CW:0]   off_r [2];

   always_comb begin
      per_x  = (dreg_r[dpg_pkg::IDX_PER] == '0) ? dpg_pkg::FULL_PER
                                                 : {1'b0, dreg_r[dpg_pkg::IDX_PER]};
      w1_x   = (dreg_r[dpg_pkg::IDX_W1] == '0) ? dpg_pkg::FULL_PER : {1'b0, dreg_r[dpg_pkg::IDX_W1]};
      w2_x   = (dreg_r[dpg_pkg::IDX_W2] == '0) ? dpg_pkg::FULL_PER : {1'b0, dreg_r[dpg_pkg::IDX_W2]};
      half_x = per_x >> 1;
      case (mode_sel)
         dpg_pkg::MODE_INDEP: begin
            on_nxt[0]  = {1'b0, dreg_r[dpg_pkg::IDX_DT1]};
            off_nxt[0] = w1_x;
            on_nxt[1]  = {1'b0, dreg_r[dpg_pkg::IDX_DT2]};
            off_nxt[1] = w2_x;
         end
         dpg_pkg::MODE_VAR: begin
            on_nxt[0]  = {1'b0, dreg_r[dpg_pkg::IDX_DT1]};
            off_nxt[0] = w1_x;
            on_nxt[1]  = w1_x + {1'b0, dreg_r[dpg_pkg::IDX_DT1]};
            off_nxt[1] = per_x;
         end
         dpg_pkg::MODE_HALF: begin
            on_nxt[0]  = {1'b0, dreg_r[dpg_pkg::IDX_DT1]};
            off_nxt[0] = half_x;
            on_nxt[1]  = half_x + {1'b0, dreg_r[dpg_pkg::IDX_DT1]};
            off_nxt[1] = per_x;
         end
         default: begin
            on_nxt[0]  = '0;
            off_nxt[0] = '0;
            on_nxt[1]  = '0;
            off_nxt[1] = '0;
         end
      endcase
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         xfer_pend_r <= 1'b0;
         per_c_r     <= dpg_pkg::FULL_PER;
         on_r[0]     <= '0;
         on_r[1]     <= '0;
         off_r[0]    <= '0;
         off_r[1]    <= '0;
      end else begin
         if (xfer_pend_r && cnt_zero) begin
            per_c_r  <= per_x;
            on_r[0]  <= on_nxt[0];
            on_r[1]  <= on_nxt[1];
            off_r[0] <= off_nxt[0];
            off_r[1] <= off_nxt[1];
         end
         if (per_hi_wr) begin
            xfer_pend_r <= 1'b1;
         end else if (cnt_zero) begin
            xfer_pend_r <= 1'b0;
         end
      end
   end

   dpg_wave_out #(.CW(CW)) u_out_one (
      .clock_in      (clock_in),
      .rstn_in       (rstn_in),
      .cnt_in        (cnt_r),
      .on_at_in      (on_r[0]),
      .off_at_in     (off_r[0]),
      .init_level_in (ini1),
      .load_init_in  (load_init),
      .run_in        (st_r == dpg_pkg::ST_COUNT),
      .pin_out       (pulse_out_one_out)
   );

   dpg_wave_out #(.CW(CW)) u_out_two (
      .clock_in      (clock_in),
      .rstn_in       (rstn_in),
      .cnt_in        (cnt_r),
      .on_at_in      (on_r[1]),
      .off_at_in     (off_r[1]),
      .init_level_in (ini2),
      .load_init_in  (load_init),
      .run_in        (st_r == dpg_pkg::ST_COUNT),
      .pin_out       (pulse_out_two_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   // capture buffer and protected capture registers
   logic [CW-1:0] buf_rise_r, buf_fall_r, rise_capture_r, fall_capture_r;
   logic          prot_r, cap_on;

   assign cap_on = run_r && (src_sel == dpg_pkg::SRC_CAP) && (st_r == dpg_pkg::ST_COUNT);

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         buf_rise_r     <= '0;
         buf_fall_r     <= '0;
         rise_capture_r <= '0;
         fall_capture_r <= '0;
      end else begin
         if (cap_on && rise) buf_rise_r <= cnt_r;
         if (cap_on && fall) buf_fall_r <= cnt_r;
         if (cap_on && per_evt && !prot_r) begin
            // an edge on the last count still belongs to this period
            rise_capture_r <= rise ? cnt_r : buf_rise_r;
            fall_capture_r <= fall ? cnt_r : buf_fall_r;
         end
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         prot_r <= 1'b0;
      end else if (rd_take && s_axi_araddr_in == dpg_pkg::ADDR_CAPR) begin
         prot_r <= 1'b1;
      end else if (rd_take && s_axi_araddr_in == dpg_pkg::ADDR_CAPF) begin
         prot_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      case (s_axi_araddr_in)
         dpg_pkg::ADDR_CTRL: rd_val[CW-1:0] = ctrl_r;
         dpg_pkg::ADDR_CAPR: rd_val[CW-1:0] = rise_capture_r;
         dpg_pkg::ADDR_CAPF: rd_val[CW-1:0] = fall_capture_r;
         dpg_pkg::ADDR_STAT: begin
            rd_val[dpg_pkg::STAT_COUNT] = (st_r == dpg_pkg::ST_COUNT);
            rd_val[dpg_pkg::STAT_WAIT]  = (st_r == dpg_pkg::ST_WAIT);
            rd_val[dpg_pkg::STAT_PROT]  = prot_r;
            rd_val[dpg_pkg::STAT_CNT_LSB +: CW] = cnt_r;
         end
         default: begin
            rd_hit = 1'b0;
            for (int i = 0; i < dpg_pkg::NDATA; i++) begin
               if (s_axi_araddr_in == dpg_pkg::DATA_OFS[i]) begin
                  rd_val[CW-1:0] = dreg_r[i];
                  rd_hit         = 1'b1;
               end
            end
         end
      endcase
   end

endmodule

// [core/dpg_wave_out.sv]
// one pulse output: level follows the counter window or the initial level
// assumes bounds are stable while counting; window is on_at <= cnt < off_at
module dpg_wave_out #(
   parameter int CW = 10
) (
   // clock and reset
   input  wire logic          clock_in,
   input  wire logic          rstn_in,
   // control
   input  wire logic [CW-1:0] cnt_in,
   input  wire logic [CW:0]   on_at_in,
   input  wire logic [CW:0]   off_at_in,
   input  wire logic          init_level_in,
   input  wire logic          load_init_in,
   input  wire logic          run_in,
   // pin
   output logic               pin_out
);

   logic active;

   assign active = ({1'b0, cnt_in} >= on_at_in) && ({1'b0, cnt_in} < off_at_in);

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pin_out <= 1'b0;
      end else if (load_init_in) begin
         pin_out <= init_level_in;
      end else if (run_in) begin
         pin_out <= init_level_in ^ active;
      end
   end

endmodule

// [dv/dpg_monitor.sv]
// dpg_top port checker
// assumes one clock, async low reset
module dpg_monitor (
   input wire logic clock_in, rstn_in, s_axi_awvalid_in, s_axi_awready_out,
   s_axi_wvalid_in, s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in,
   s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in,
   period_match_irq_out, trigger_start_irq_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rstn_in);
   sequence s_aw; s_axi_awvalid_in && s_axi_awready_out; endsequence
   sequence s_w; s_axi_wvalid_in && s_axi_wready_out; endsequence
   property p_wl; s_aw and s_w |-> ##2 s_axi_bvalid_out; endproperty
   a_wl: assert property (p_wl) else $error("late b");
   property p_bh; s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out; endproperty
   a_bh: assert property (p_bh) else $error("b lost");
   property p_bf; s_aw |=> !s_axi_awready_out; endproperty
   a_bf: assert property (p_bf) else $error("aw not held off");
   property p_rl; s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out; endproperty
   a_rl: assert property (p_rl) else $error("late r");
   property p_rh; s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out; endproperty
   a_rh: assert property (p_rh) else $error("r lost");
   property p_rf; s_axi_rvalid_out |-> !s_axi_arready_out; endproperty
   a_rf: assert property (p_rf) else $error("ar early");
   property p_pm; period_match_irq_out |=> !period_match_irq_out; endproperty
   a_pm: assert property (p_pm) else $error("pm long");
   property p_ts; trigger_start_irq_out |=> !trigger_start_irq_out; endproperty
   a_ts: assert property (p_ts) else $error("ts long");
endmodule
bind dpg_top dpg_monitor u_mon (.*);

// [dv/dpg_trig_model.sv]
// trigger pin partner: rests at a level or toggles
// assumes commands change just after a rising edge
module dpg_trig_model (
   input  wire logic clock_in,
   input  wire logic idle_level_in,
   input  wire logic pulse_in,
   output logic      pin_out
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge clock_in) begin
      pin_out <= pulse_in ? !pin_out : idle_level_in;
   end
endmodule

// [dv/tb.sv]
// self-checking bench for the pulse generator
// assumes the trigger model and bound monitor
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 0, rstn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, idl = 1, pls = 0;
   logic        pin, awr, wrr, bv, arr, rv;
   logic [5:0]  aw = 0;
   logic [31:0] wd = 0, rdat, rd_d;
   logic [1:0]  rs, rd_r;
   wire  [3:0]  ev;
   int          bad_count = 0, tests_run = 0, seed = 47, cyc = 0, v, cnt[4];
   int          cfg[5] = '{0, 2, 4, 1, 3};
   always #10 clk = !clk;
   dpg_trig_model PIN (.clock_in(clk), .idle_level_in(idl), .pulse_in(pls), .pin_out(pin));
   dpg_top DUT (.clock_in(clk), .rstn_in(rstn), .s_axi_awaddr_in(aw), .s_axi_awvalid_in(awv),
      .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'h3), .s_axi_wvalid_in(wv),
      .s_axi_wready_out(wrr), .s_axi_bresp_out(), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
      .s_axi_araddr_in(aw), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
      .s_axi_rdata_out(rdat), .s_axi_rresp_out(rs), .s_axi_rvalid_out(rv),
      .s_axi_rready_in(rry), .ext_trigger_in(pin), .pulse_out_one_out(ev[0]),
      .pulse_out_two_out(ev[1]), .period_match_irq_out(ev[2]), .trigger_start_irq_out(ev[3]));
   task automatic bus(bit w, logic [5:0] a, int d);
      @(posedge clk);
      aw <= a;
      wd <= d;
      awv <= w;
      wv <= w;
      bry <= w;
      arv <= !w;
      rry <= !w;
      do begin
         @(posedge clk);
         if (awr) awv <= 0;
         if (wrr) wv <= 0;
         if (arr) arv <= 0;
         rd_d = rdat;
         rd_r = rs;
      end while (!(w ? bv : rv));
      bry <= 0;
      rry <= 0;
   endtask
   task automatic run_n(int n);
      cnt = '{0, 0, 0, 0};
      repeat (n) begin
         @(posedge clk);
         foreach (cnt[i]) cnt[i] += ev[i] === 1'b1;
      end
   endtask
   task automatic chk(string n, int e, logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED %s exp %0d got %0d", n, e, s);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         bad_count++;
         conclude;
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1;
      bus(1, 6'h0C, 32'h400);
      bus(0, 6'h0C, 0);
      chk("per", 0, rd_d);
      repeat (3) begin
         v = $random(seed) & 32'h3FF | 1;
         bus(1, 6'h14, v);
         bus(0, 6'h14, 0);
         chk("w2", v, rd_d);
      end
      bus(0, 6'h24, 0);
      chk("resp", dpg_pkg::RESP_SLVERR, rd_r);
      foreach (cfg[i]) bus(1, dpg_pkg::DATA_OFS[i], cfg[i]);
      repeat (2) begin
         bus(1, 6'h00, 32'h001);
         repeat (8) @(posedge clk);
         run_n(40);
         chk("o1", cfg[0] >= cfg[2] ? 0 : (cfg[1] - cfg[0]) * 40 / cfg[2], cnt[0]);
         chk("o2", (cfg[4] - cfg[3]) * 40 / cfg[2], cnt[1]);
         chk("pm", 40 / cfg[2], cnt[2]);
         cfg[0] = 5;
         bus(1, 6'h04, 5);
         bus(1, 6'h0C, 4);
      end
      bus(1, 6'h00, 32'h201);
      bus(0, dpg_pkg::ADDR_CAPF, 0);
      bus(1, 6'h04, 1);
      bus(1, 6'h08, 3);
      bus(1, 6'h0C, 8);
      pls <= 1;
      repeat (16) @(posedge clk);
      run_n(40);
      chk("v1", (3 - 1) * 40 / 8, cnt[0]);
      chk("v2", (8 - 3 - 1) * 40 / 8, cnt[1]);
      bus(0, dpg_pkg::ADDR_CAPR, 0);
      v = rd_d;
      bus(0, dpg_pkg::ADDR_STAT, 0);
      chk("prot", 1, rd_d[dpg_pkg::STAT_PROT]);
      bus(0, dpg_pkg::ADDR_CAPF, 0);
      chk("cap", 2 * 8 - 3, v + rd_d);
      bus(0, dpg_pkg::ADDR_STAT, 0);
      chk("unprot", 0, rd_d[dpg_pkg::STAT_PROT]);
      pls <= 0;
      bus(1, 6'h00, 32'h010);
      bus(1, 6'h0C, 4);
      pls <= 1;
      run_n(20);
      chk("ts0", 0, cnt[3]);
      pls <= 0;
      bus(1, 6'h00, 32'h011);
      run_n(10);
      chk("wait", 0, cnt[2]);
      idl <= 0;
      run_n(20);
      chk("ts1", 1, cnt[3]);
      chk("run", 1, cnt[2] > 3);
      bus(1, 6'h00, 32'h015);
      idl <= 1;
      run_n(4);
      idl <= 0;
      run_n(20);
      chk("once", 1, cnt[2]);
      conclude;
   end
endmodule
